// ===== design/ptm_timer_pair.sv
// paired 8-bit timers with shared output flip-flop and apb registers
//
// Contract
// - action code 1,0 inverts the output flip-flop at once, running or not
// - action code 0,0 clears the flip-flop, code 0,1 sets it
// - flip-flop and compare registers read back nothing of their contents
// - pair mode 01 cascades both counters into one 16-bit timer
// - cascaded upper counts lower overflows; lower uses its own tap select
// - cascaded low compare write suspends comparison, high compare write resumes it
// - cascaded low match raises lower irq, no clear, no flip-flop toggle
// - cascaded joint match clears both, upper irq, toggles when enabled
// - independent mode: each clears on match; upper may count lower matches
// - independent mode: source select 0 lower match, 1 upper match
// - pulse mode: upper counter toggles output on duty or period match
// - pulse mode: lower counter may still count but drives nothing
// - pulse polarity follows the flip-flop preset before start
// - pwm uses upper timer only; lower stays an independent timer
// - pwm toggles on compare match and on 2^n-1 overflow, which clears
// - pwm period code 01,10,11 gives 63, 127, 255 clocks
// - pwm compare match raises upper irq; compare writes act at once
// - compare value zero matches on counter overflow, except the pwm compare, which then never matches
// - in independent mode a match clears the counter, raises irq, toggles when enabled and its timer is the selected source
`timescale 1ns/100ps

module ptm_timer_pair
(
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             pair_output_pin_o,
	output logic             lower_match_irq_o,
	output logic             upper_match_irq_o
);

	// ********************************************************
	// helpers
	// ********************************************************

	// match on the tick that would bring cnt to cmp; zero means overflow
	function automatic logic next_eq(input logic [7:0] cnt,
		input logic [7:0] cmp);
		logic [7:0] inc;
		inc = cnt + ptm_pkg::CNT_ONE;
		if (cmp == ptm_pkg::CNT_ZERO)
		begin
			next_eq = (cnt == ptm_pkg::CNT_MAX);
		end
		else
		begin
			next_eq = (inc == cmp);
		end
	endfunction

	// pick a prescaler tap; code 00 gives the alternate source
	function automatic logic tap_pick(input logic [1:0] code,
		input logic [2:0] taps, input logic alt);
		logic t;
		t = alt;
		unique case (code)
			ptm_pkg::CLK_ALT:  t = alt;
			ptm_pkg::CLK_T1:   t = taps[0];
			ptm_pkg::CLK_T16:  t = taps[1];
			ptm_pkg::CLK_T256: t = taps[2];
		endcase
		tap_pick = t;
	endfunction

	// pwm period top from the period field
	function automatic logic [7:0] pwm_top(input logic [1:0] code);
		logic [7:0] top;
		top = ptm_pkg::PWM_TOP8;
		unique case (code)
			ptm_pkg::PWM_N6: top = ptm_pkg::PWM_TOP6;
			ptm_pkg::PWM_N7: top = ptm_pkg::PWM_TOP7;
			ptm_pkg::PWM_N8: top = ptm_pkg::PWM_TOP8;
			default:         top = ptm_pkg::PWM_TOP8;
		endcase
		pwm_top = top;
	endfunction

	// ********************************************************
	// apb decode
	// ********************************************************
	logic       wr_en;
	logic       rd_setup;
	logic       mapped;
	logic [7:0] wbyte;

	// zero wait states; a write lands at the access edge
	assign mapped = (paddr_i == ptm_pkg::RUN_OFS) ||
		(paddr_i == ptm_pkg::CLKSEL_OFS) ||
		(paddr_i == ptm_pkg::MODE_OFS) ||
		(paddr_i == ptm_pkg::FFCTL_OFS) ||
		(paddr_i == ptm_pkg::LCMP_OFS) ||
		(paddr_i == ptm_pkg::UCMP_OFS) ||
		(paddr_i == ptm_pkg::STATUS_OFS);
	assign wr_en     = psel_i && penable_i && pwrite_i && pstrb_i[0] && mapped;
	assign rd_setup  = psel_i && !penable_i && !pwrite_i;
	assign wbyte     = pwdata_i[7:0];
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;

	// ********************************************************
	// software registers
	// ********************************************************
	logic [2:0]  run_control_reg;
	logic [2:0]  run_control_next;
	logic [3:0]  timer_clock_select_reg;
	logic [3:0]  timer_clock_select_next;
	logic [3:0]  timer_mode_reg;
	logic [3:0]  timer_mode_next;
	logic [1:0]  flipflop_control_reg;
	logic [1:0]  flipflop_control_next;
	logic [7:0]  lower_compare_reg;
	logic [7:0]  lower_compare_next;
	logic [7:0]  upper_compare_reg;
	logic [7:0]  upper_compare_next;
	logic        cmp_hold_reg;
	logic        cmp_hold_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [1:0]  pair_mode_field;
	logic [1:0]  pwm_period_field;
	logic [7:0]  lower_counter;
	logic [7:0]  upper_counter;

	assign pair_mode_field  = timer_mode_reg[ptm_pkg::PAIR_MODE_LSB +: 2];
	assign pwm_period_field = timer_mode_reg[ptm_pkg::PWM_LSB +: 2];

	// writes and the read snapshot taken in the setup cycle
	always_comb
	begin
		run_control_next        = run_control_reg;
		timer_clock_select_next = timer_clock_select_reg;
		timer_mode_next         = timer_mode_reg;
		flipflop_control_next   = flipflop_control_reg;
		lower_compare_next      = lower_compare_reg;
		upper_compare_next      = upper_compare_reg;
		cmp_hold_next           = cmp_hold_reg;
		prdata_next             = prdata_reg;
		if (wr_en)
		begin
			unique case (paddr_i)
				ptm_pkg::RUN_OFS:    run_control_next = wbyte[2:0];
				ptm_pkg::CLKSEL_OFS: timer_clock_select_next = wbyte[3:0];
				ptm_pkg::MODE_OFS:   timer_mode_next = wbyte[3:0];
				ptm_pkg::FFCTL_OFS:  flipflop_control_next = wbyte[1:0];
				ptm_pkg::LCMP_OFS:
				begin
					lower_compare_next = wbyte; // takes effect at once
					if (pair_mode_field == ptm_pkg::MODE_CASCADE)
					begin
						cmp_hold_next = 1'b1;
					end
				end
				ptm_pkg::UCMP_OFS:
				begin
					upper_compare_next = wbyte;
					cmp_hold_next      = 1'b0;
				end
				default:             cmp_hold_next = cmp_hold_reg;
			endcase
		end
		if (rd_setup)
		begin
			prdata_next = 32'h0000_0000;
			unique case (paddr_i)
				ptm_pkg::RUN_OFS:    prdata_next[2:0] = run_control_reg;
				ptm_pkg::CLKSEL_OFS: prdata_next[3:0] = timer_clock_select_reg;
				ptm_pkg::MODE_OFS:   prdata_next[3:0] = timer_mode_reg;
				ptm_pkg::FFCTL_OFS:
				begin
					// flip-flop value hidden; action field reads as keep
					prdata_next[1:0] = flipflop_control_reg;
					prdata_next[ptm_pkg::FF_ACT_LSB +: 2] = ptm_pkg::FFA_KEEP;
				end
				ptm_pkg::STATUS_OFS:
				begin
					prdata_next[ptm_pkg::ST_LCNT_LSB +: 8] = lower_counter;
					prdata_next[ptm_pkg::ST_UCNT_LSB +: 8] = upper_counter;
					prdata_next[ptm_pkg::ST_HOLD_BIT]      = cmp_hold_reg;
				end
				default:             prdata_next = 32'h0000_0000;
			endcase
		end
	end

	// register only
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			run_control_reg        <= ptm_pkg::RUN_RST;
			timer_clock_select_reg <= ptm_pkg::CLKSEL_RST;
			timer_mode_reg         <= ptm_pkg::MODE_RST;
			flipflop_control_reg   <= ptm_pkg::FFCTL_RST;
			lower_compare_reg      <= ptm_pkg::CMP_RST;
			upper_compare_reg      <= ptm_pkg::CMP_RST;
			cmp_hold_reg           <= 1'b0;
			prdata_reg             <= 32'h0000_0000;
		end
		else
		begin
			run_control_reg        <= run_control_next;
			timer_clock_select_reg <= timer_clock_select_next;
			timer_mode_reg         <= timer_mode_next;
			flipflop_control_reg   <= flipflop_control_next;
			lower_compare_reg      <= lower_compare_next;
			upper_compare_reg      <= upper_compare_next;
			cmp_hold_reg           <= cmp_hold_next;
			prdata_reg             <= prdata_next;
		end
	end

	assign prdata_o = prdata_reg;

	// ********************************************************
	// prescaler
	// ********************************************************
	logic [10:0] pre_reg;
	logic [10:0] pre_next;
	logic [2:0]  taps;

	// stopping the prescaler clears it so restarts are phase aligned
	always_comb
	begin
		pre_next = ptm_pkg::PRE_W'(0);
		if (run_control_reg[ptm_pkg::RUN_PRE_BIT])
		begin
			pre_next = pre_reg + 11'h001;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pre_reg <= 11'h000;
		end
		else
		begin
			pre_reg <= pre_next;
		end
	end

	// one-cycle taps at fc/8, fc/128, fc/2048
	assign taps[0] = run_control_reg[ptm_pkg::RUN_PRE_BIT] &&
		((pre_reg & ptm_pkg::TAP1_MASK) == ptm_pkg::TAP1_MASK);
	assign taps[1] = run_control_reg[ptm_pkg::RUN_PRE_BIT] &&
		((pre_reg & ptm_pkg::TAP16_MASK) == ptm_pkg::TAP16_MASK);
	assign taps[2] = run_control_reg[ptm_pkg::RUN_PRE_BIT] &&
		((pre_reg & ptm_pkg::TAP256_MASK) == ptm_pkg::TAP256_MASK);

	// ********************************************************
	// match and mode logic
	// ********************************************************
	logic [1:0] lower_clk;
	logic [1:0] upper_clk;
	logic       lower_tick;
	logic       lower_hit;
	logic       upper_tick;
	logic       upper_clear;
	logic       lower_clear;
	logic       hw_toggle;
	logic       lirq;
	logic       uirq;
	logic       ie;
	logic       invert_source_select;
	logic       joint;
	logic       u_eq;
	logic       duty_hit;
	logic       per_hit;
	logic [7:0] top;

	assign lower_clk  = timer_clock_select_reg[ptm_pkg::CLK_LOWER_LSB +: 2];
	assign upper_clk  = timer_clock_select_reg[ptm_pkg::CLK_UPPER_LSB +: 2];
	assign ie         = flipflop_control_reg[ptm_pkg::FF_IE_BIT];
	assign invert_source_select = flipflop_control_reg[ptm_pkg::FF_IS_BIT];
	assign lower_tick = tap_pick(lower_clk, taps, 1'b0);
	assign lower_hit  = lower_tick &&
		next_eq(lower_counter, lower_compare_reg);
	assign top        = pwm_top(pwm_period_field);

	// one case per pair mode; the lower timer keeps its own match path in independent and pwm modes
	always_comb
	begin
		upper_tick  = tap_pick(upper_clk, taps, 1'b0);
		lower_clear = lower_hit;
		upper_clear = 1'b0;
		hw_toggle   = 1'b0;
		lirq        = lower_hit;
		uirq        = 1'b0;
		joint       = 1'b0;
		u_eq        = 1'b0;
		duty_hit    = 1'b0;
		per_hit     = 1'b0;
		unique case (pair_mode_field)
			ptm_pkg::MODE_INDEP:
			begin
				// code 00 lets the upper count lower matches
				upper_tick  = tap_pick(upper_clk, taps, lower_hit);
				per_hit     = upper_tick &&
					next_eq(upper_counter, upper_compare_reg);
				upper_clear = per_hit;
				uirq        = per_hit;
				hw_toggle   = ie && (invert_source_select ?
					per_hit : lower_hit);
			end
			ptm_pkg::MODE_CASCADE:
			begin
				// upper ignores its select and counts overflows
				upper_tick = lower_tick &&
					(lower_counter == ptm_pkg::CNT_MAX);
				// zero low byte matches on overflow, when upper steps too
				u_eq = (lower_compare_reg == ptm_pkg::CNT_ZERO) ?
					next_eq(upper_counter, upper_compare_reg) :
					(upper_counter == upper_compare_reg);
				joint       = !cmp_hold_reg && lower_hit && u_eq;
				lirq        = !cmp_hold_reg && lower_hit;
				lower_clear = joint;
				upper_clear = joint;
				uirq        = joint;
				hw_toggle   = ie && joint;
			end
			ptm_pkg::MODE_PULSE:
			begin
				// lower count clears on its own compare match and drives nothing
				duty_hit    = upper_tick &&
					next_eq(upper_counter, lower_compare_reg);
				per_hit     = upper_tick &&
					next_eq(upper_counter, upper_compare_reg);
				upper_clear = per_hit;
				lirq        = duty_hit;
				uirq        = per_hit;
				hw_toggle   = ie && (duty_hit || per_hit);
			end
			ptm_pkg::MODE_PWM:
			begin
				// lower stays a plain 8-bit timer
				duty_hit    = upper_tick &&
					((upper_counter + ptm_pkg::CNT_ONE) == upper_compare_reg);
				per_hit     = upper_tick &&
					((upper_counter + ptm_pkg::CNT_ONE) == top);
				upper_clear = per_hit;
				uirq        = duty_hit;
				hw_toggle   = ie && (duty_hit || per_hit);
			end
		endcase
	end

	ptm_counter u_lower
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.run_i     (run_control_reg[ptm_pkg::RUN_LOWER_BIT]),
		.tick_i    (lower_tick),
		.clear_i   (lower_clear),
		.count_o   (lower_counter)
	);

	ptm_counter u_upper
	(
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.run_i     (run_control_reg[ptm_pkg::RUN_UPPER_BIT]),
		.tick_i    (upper_tick),
		.clear_i   (upper_clear),
		.count_o   (upper_counter)
	);

	// ********************************************************
	// output flip-flop and match pulses
	// ********************************************************
	logic       pair_output_flipflop_reg;
	logic       pair_output_flipflop_next;
	logic       lirq_reg;
	logic       uirq_reg;
	logic [1:0] flipflop_action_code;
	logic       ff_wr;

	assign ff_wr = wr_en && (paddr_i == ptm_pkg::FFCTL_OFS);
	assign flipflop_action_code = wbyte[ptm_pkg::FF_ACT_LSB +: 2];

	// software set or clear beats a hardware toggle in the same cycle;
	// a software invert and a hardware toggle together cancel
	always_comb
	begin
		pair_output_flipflop_next = pair_output_flipflop_reg ^ hw_toggle;
		if (ff_wr)
		begin
			unique case (flipflop_action_code)
				ptm_pkg::FFA_CLEAR:  pair_output_flipflop_next = 1'b0;
				ptm_pkg::FFA_SET:    pair_output_flipflop_next = 1'b1;
				ptm_pkg::FFA_INVERT: pair_output_flipflop_next =
					!(pair_output_flipflop_reg ^ hw_toggle);
				ptm_pkg::FFA_KEEP:   pair_output_flipflop_next =
					pair_output_flipflop_reg ^ hw_toggle;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pair_output_flipflop_reg <= ptm_pkg::FF_RST;
			lirq_reg                 <= 1'b0;
			uirq_reg                 <= 1'b0;
		end
		else
		begin
			pair_output_flipflop_reg <= pair_output_flipflop_next;
			lirq_reg                 <= lirq;
			uirq_reg                 <= uirq;
		end
	end

	// polarity is whatever the preset left in the flip-flop
	assign pair_output_pin_o = pair_output_flipflop_reg;
	assign lower_match_irq_o = lirq_reg;
	assign upper_match_irq_o = uirq_reg;

endmodule

// ===== design/ptm_pkg.sv
// constants for the paired 8-bit timer block
package ptm_pkg;

	// ********************************************************
	// register byte offsets on the apb bus
	// ********************************************************
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam logic [7:0]  RUN_OFS     = 8'h00;
	localparam logic [7:0]  CLKSEL_OFS  = 8'h04;
	localparam logic [7:0]  MODE_OFS    = 8'h08;
	localparam logic [7:0]  FFCTL_OFS   = 8'h0c;
	localparam logic [7:0]  LCMP_OFS    = 8'h10;
	localparam logic [7:0]  UCMP_OFS    = 8'h14;
	localparam logic [7:0]  STATUS_OFS  = 8'h18;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int unsigned RUN_LOWER_BIT  = 0;
	localparam int unsigned RUN_UPPER_BIT  = 1;
	localparam int unsigned RUN_PRE_BIT    = 2;
	localparam int unsigned RUN_W          = 3;
	localparam int unsigned CLK_LOWER_LSB  = 0;
	localparam int unsigned CLK_UPPER_LSB  = 2;
	localparam int unsigned PWM_LSB        = 0;
	localparam int unsigned PAIR_MODE_LSB  = 2;
	localparam int unsigned FF_IE_BIT      = 0;
	localparam int unsigned FF_IS_BIT      = 1;
	localparam int unsigned FF_ACT_LSB     = 2;
	localparam int unsigned ST_LCNT_LSB    = 0;
	localparam int unsigned ST_UCNT_LSB    = 8;
	localparam int unsigned ST_HOLD_BIT    = 16;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [2:0] RUN_RST    = 3'h0;
	localparam logic [3:0] CLKSEL_RST = 4'h0;
	localparam logic [3:0] MODE_RST   = 4'h0;
	localparam logic [1:0] FFCTL_RST  = 2'h0;
	localparam logic [7:0] CMP_RST    = 8'h00;
	localparam logic       FF_RST     = 1'b0;

	// ********************************************************
	// codes of the clock select, pair mode, action and pwm period fields
	// ********************************************************
	localparam logic [1:0] CLK_ALT      = 2'b00;
	localparam logic [1:0] CLK_T1       = 2'b01;
	localparam logic [1:0] CLK_T16      = 2'b10;
	localparam logic [1:0] CLK_T256     = 2'b11;
	localparam logic [1:0] MODE_INDEP   = 2'b00;
	localparam logic [1:0] MODE_CASCADE = 2'b01;
	localparam logic [1:0] MODE_PULSE   = 2'b10;
	localparam logic [1:0] MODE_PWM     = 2'b11;
	localparam logic [1:0] FFA_CLEAR    = 2'b00;
	localparam logic [1:0] FFA_SET      = 2'b01;
	localparam logic [1:0] FFA_INVERT   = 2'b10;
	localparam logic [1:0] FFA_KEEP     = 2'b11;
	localparam logic [1:0] PWM_N6       = 2'b01;
	localparam logic [1:0] PWM_N7       = 2'b10;
	localparam logic [1:0] PWM_N8       = 2'b11;

	// ********************************************************
	// prescaler taps, pwm periods and counter values
	// ********************************************************
	localparam int unsigned PRE_W     = 11;
	localparam logic [10:0] TAP1_MASK = 11'h007;
	localparam logic [10:0] TAP16_MASK = 11'h07f;
	localparam logic [10:0] TAP256_MASK = 11'h7ff;
	localparam logic [7:0]  PWM_TOP6  = 8'h3f;
	localparam logic [7:0]  PWM_TOP7  = 8'h7f;
	localparam logic [7:0]  PWM_TOP8  = 8'hff;
	localparam logic [7:0]  CNT_MAX   = 8'hff;
	localparam logic [7:0]  CNT_ONE   = 8'h01;
	localparam logic [7:0]  CNT_ZERO  = 8'h00;

endpackage

// ===== design/ptm_counter.sv
// one 8-bit up-counter with run, tick and clear
`timescale 1ns/100ps

module ptm_counter
(
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	input  wire logic       run_i,
	input  wire logic       tick_i,
	input  wire logic       clear_i,
	output logic [7:0]      count_o
);

	// ********************************************************
	// count state
	// ********************************************************
	logic [7:0] count_reg;
	logic [7:0] count_next;

	// a stopped counter is held at zero; clear beats the tick
	always_comb
	begin
		count_next = count_reg;
		if (!run_i)
		begin
			count_next = ptm_pkg::CNT_ZERO;
		end
		else if (clear_i)
		begin
			count_next = ptm_pkg::CNT_ZERO;
		end
		else if (tick_i)
		begin
			count_next = count_reg + ptm_pkg::CNT_ONE; // wraps at 8 bits
		end
	end

	// register only
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			count_reg <= ptm_pkg::CNT_ZERO;
		end
		else
		begin
			count_reg <= count_next;
		end
	end

	assign count_o = count_reg;

endmodule

// ===== tb/ptm_pin_probe.sv
// load on the timer output pin that measures its period and high time
`timescale 1ns/100ps

module ptm_pin_probe
(
	input  wire logic        clk_i,
	input  wire logic        pin_i,
	output logic [15:0]      per_o,
	output logic [15:0]      high_o
);
	logic        last_reg;
	logic [15:0] pcnt_reg;
	logic [15:0] hcnt_reg;

	// edge spacing counted in system clocks, pin seen once per cycle
	always_ff @(posedge clk_i)
	begin
		last_reg <= pin_i;
		pcnt_reg <= (pin_i && !last_reg) ? 16'h0001 : pcnt_reg + 16'h0001;
		hcnt_reg <= last_reg ? hcnt_reg + 16'h0001 : 16'h0001;
		if (pin_i && !last_reg)
			per_o <= pcnt_reg;
		if (!pin_i && last_reg)
			high_o <= hcnt_reg;
	end
endmodule

// ===== tb/ptm_timer_pair_properties.sv
// port-level assertions for the paired timer block
`timescale 1ns/100ps

module ptm_timer_pair_properties
(
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pready_o,
	input  wire logic        pslverr_o,
	input  wire logic        pair_output_pin_o,
	input  wire logic        lower_match_irq_o,
	input  wire logic        upper_match_irq_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	logic acc;
	logic wff;
	logic rd_cmp;

	// access-phase decodes shared by the properties
	assign acc = psel_i && penable_i;
	assign wff = acc && pwrite_i && pstrb_i[0]
		&& paddr_i == ptm_pkg::FFCTL_OFS;
	assign rd_cmp = acc && !pwrite_i && (paddr_i == ptm_pkg::LCMP_OFS
		|| paddr_i == ptm_pkg::UCMP_OFS);

	a_ready_high: assert property (pready_o)
		else $error("pready low");
	a_err_access: assert property (pslverr_o |-> acc)
		else $error("error outside access phase");
	a_err_unmapped: assert property (acc && paddr_i == 8'h1c |-> pslverr_o)
		else $error("unmapped access without error");
	a_lirq_pulse: assert property (lower_match_irq_o |=> !lower_match_irq_o)
		else $error("lower irq longer than one cycle");
	a_uirq_pulse: assert property (upper_match_irq_o |=> !upper_match_irq_o)
		else $error("upper irq longer than one cycle");
	a_ff_clear: assert property (
		wff && pwdata_i[3:2] == ptm_pkg::FFA_CLEAR |=> !pair_output_pin_o)
		else $error("flip-flop not cleared");
	a_ff_set: assert property (
		wff && pwdata_i[3:2] == ptm_pkg::FFA_SET |=> pair_output_pin_o)
		else $error("flip-flop not set");
	a_cmp_hidden: assert property (rd_cmp |-> prdata_o == 32'h0)
		else $error("compare value readable");
	a_ffval_hidden: assert property (
		acc && !pwrite_i && paddr_i == ptm_pkg::FFCTL_OFS
		|-> prdata_o[3:2] == 2'b11)
		else $error("action field readable");
endmodule

bind ptm_timer_pair ptm_timer_pair_properties u_chk
(
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o),
	.pair_output_pin_o(pair_output_pin_o),
	.lower_match_irq_o(lower_match_irq_o),
	.upper_match_irq_o(upper_match_irq_o)
);

// ===== tb/ptm_timer_pair_test.sv
// self-checking bench for the paired timer block
`timescale 1ns/100ps

module ptm_timer_pair_test;
	localparam int T = int'(ptm_pkg::TAP1_MASK) + 1;
	logic        clk;
	logic        rstn;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        perr;
	logic        pin;
	logic        lirq;
	logic        uirq;
	logic [15:0] per;
	logic [15:0] hi;
	logic [31:0] rd;
	int          g;
	int          error_cnt;
	int          checks_done;

	ptm_timer_pair uut (.clk_sys_i(clk), .resetn_i(rstn), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(perr), .pair_output_pin_o(pin),
		.lower_match_irq_o(lirq), .upper_match_irq_o(uirq));
	ptm_pin_probe probe (.clk_i(clk), .pin_i(pin), .per_o(per),
		.high_o(hi));

	always #25 clk = ~clk;

	task automatic report_and_stop;
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		// no cycle limit here: only the watchdog ends a hung wait
		while (!pready)
		begin
			@(posedge clk);
		end
		rd = (a == 8'h1c) ? {31'h0, perr} : prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// stop, program, preset and restart the pair
	task automatic go(input logic [3:0] ck, input logic [3:0] md,
		input logic [3:0] ff, input logic [7:0] lc, input logic [7:0] uc,
		input logic [2:0] rn);
		apb(1'b1, ptm_pkg::RUN_OFS, 32'h0);
		apb(1'b1, ptm_pkg::CLKSEL_OFS, {28'h0, ck});
		apb(1'b1, ptm_pkg::MODE_OFS, {28'h0, md});
		apb(1'b1, ptm_pkg::LCMP_OFS, {24'h0, lc});
		apb(1'b1, ptm_pkg::UCMP_OFS, {24'h0, uc});
		apb(1'b1, ptm_pkg::FFCTL_OFS, {28'h0, ff});
		apb(1'b1, ptm_pkg::RUN_OFS, {29'h0, rn});
	endtask

	// spacing in clocks between two pulses of the chosen irq
	task automatic gap(input logic up, output int n);
		n = 0;
		while (!(up ? uirq : lirq) && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		n = 1;
		while (!(up ? uirq : lirq) && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic t_regs;
		apb(1'b0, ptm_pkg::CLKSEL_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ptm_pkg::CLKSEL_OFS, 32'h9);
		apb(1'b0, ptm_pkg::CLKSEL_OFS, 32'h0);
		chk(rd, 32'h9);
		apb(1'b1, ptm_pkg::LCMP_OFS, 32'h7);
		apb(1'b0, ptm_pkg::LCMP_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ptm_pkg::FFCTL_OFS, 32'h0);
		chk(rd, 32'hc);
		apb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h1);
	endtask

	// software clear, set and two inversions with timers stopped
	task automatic t_ff;
		logic [1:0] c [4];
		logic       e [4];
		c = '{ptm_pkg::FFA_CLEAR, ptm_pkg::FFA_SET, ptm_pkg::FFA_INVERT,
			ptm_pkg::FFA_INVERT};
		e = '{1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, ptm_pkg::FFCTL_OFS, {28'h0, c[i], 2'b00});
			@(negedge clk);
			chk({31'h0, pin}, {31'h0, e[i]});
		end
	endtask

	task automatic t_indep;
		go(4'h1, 4'h0, 4'h1, 8'h03, 8'h00, 3'b101);
		gap(1'b0, g);
		chk(g, 3 * T);
		repeat (8 * T) @(posedge clk);
		chk({16'h0, per}, 6 * T);
		go(4'h1, 4'h0, 4'h3, 8'h03, 8'h02, 3'b111);
		gap(1'b1, g);
		chk(g, 6 * T);
		repeat (16 * T) @(posedge clk);
		chk({16'h0, per}, 12 * T);
		// compare zero waits for the overflow, a full 256 ticks
		go(4'h1, 4'h0, 4'h0, 8'h00, 8'h00, 3'b101);
		gap(1'b0, g);
		chk(g, 256 * T);
	endtask

	task automatic t_casc;
		go(4'h1, 4'h4, 4'h3, 8'h02, 8'h01, 3'b111);
		apb(1'b1, ptm_pkg::LCMP_OFS, 32'h2);
		apb(1'b0, ptm_pkg::STATUS_OFS, 32'h0);
		chk({31'h0, rd[16]}, 32'h1);
		apb(1'b1, ptm_pkg::UCMP_OFS, 32'h1);
		apb(1'b0, ptm_pkg::STATUS_OFS, 32'h0);
		chk({31'h0, rd[16]}, 32'h0);
		gap(1'b1, g);
		chk(g, 258 * T);
		// low matches come 2 ticks after a joint match, then 256 later
		gap(1'b0, g);
		chk(g, 2 * T);
		gap(1'b0, g);
		chk(g, 256 * T);
	endtask

	// high-active pulse from a preset of 1; lower counter runs alongside
	task automatic t_pulse;
		go(4'h5, 4'h8, 4'h5, 8'h05, 8'h14, 3'b111);
		repeat (60 * T) @(posedge clk);
		chk({16'h0, per}, 20 * T);
		chk({16'h0, hi}, 5 * T);
		gap(1'b1, g);
		chk(g, 20 * T);
		// a duty compare write acts at once, with no wait for a period match
		apb(1'b1, ptm_pkg::LCMP_OFS, 32'h8);
		repeat (60 * T) @(posedge clk);
		chk({16'h0, hi}, 8 * T);
	endtask

	// period codes 01, 10 and 11; compare stays nonzero and below the top
	task automatic t_pwm;
		int top;
		for (int i = 1; i < 4; i++)
		begin
			top = (1 << (5 + i)) - 1;
			go(4'h5, {2'b11, 2'(i)}, 4'h1, 8'h03, 8'h10, 3'b111);
			repeat (3 * top * T) @(posedge clk);
			chk({16'h0, per}, top * T);
			chk({16'h0, hi}, (top - 16) * T);
		end
		gap(1'b0, g);
		chk(g, 3 * T);
		gap(1'b1, g);
		chk(g, top * T);
	endtask

	initial
	begin
		#(50 * 40000);
		error_cnt++;
		report_and_stop;
	end

	initial
	begin
		error_cnt = 0;
		checks_done = 0;
		clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_ff;
		t_indep;
		t_casc;
		t_pulse;
		t_pwm;
		report_and_stop;
	end
endmodule
